// >>> hw/scm_sio_regs.sv
// Register slice of a dual-core single-cycle IO block: pad enables,
// flash pad levels, two mailboxes, lock map and divider operands.
// Assumes one AXI4-Lite port per core, one clock, lock bits from
// logic on the same clock.
// Operation
// - Pad enable clear alias clears bits written as one.
// - Pad enable toggle alias inverts bits written as one.
// - Six-bit flash level register, resets zero, reads last write.
// - Same-cycle writes: core zero applied first, then core one.
// - Flash level set, clear and toggle aliases act on one bits.
// - Six-bit flash drive enable register, resets zero, reads back.
// - Flash enable set, clear and toggle aliases act on one bits.
// - Two mailbox queues, one each direction, eight 32-bit words.
// - Core pushes its outgoing queue, pops its incoming queue.
// - Core interrupt is OR of valid, overflow and underflow.
// - Pop when empty ignored, sets sticky bit 3; write clears.
// - Push when full discarded, sets sticky bit 2; write clears.
// - Bit 1 shows outgoing queue not full; resets one.
// - Bit 0 shows incoming queue not empty; resets zero.
// - Write to push port enqueues word into outgoing queue.
// - Read of pop port returns and removes oldest incoming word.
// - Read-only lock map shows all 32 lock bits.
// - Numerator register with unsigned and signed aliases.
// - Denominator register with unsigned and signed aliases.
// - Any operand write starts a new division.
// - Unsigned alias starts unsigned, signed alias signed division.
// - Ready flag low while dividing, one otherwise, resets one.
// - Dirty flag set by divider writes, cleared by quotient read.
// - Result write halts division, sets ready and dirty.
// - Signed quotient sign from operand signs, remainder from numerator.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module scm_sio_regs #(
    parameter int MB_DEPTH   = scm_pkg::MB_DEPTH,
    parameter int DIV_CYCLES = scm_pkg::DIV_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic [1:0]            s_awvalid,
    output logic      [1:0]            s_awready,
    input  wire logic [1:0][7:0]       s_awaddr,
    input  wire logic [1:0]            s_wvalid,
    output logic      [1:0]            s_wready,
    input  wire logic [1:0][31:0]      s_wdata,
    input  wire logic [1:0][3:0]       s_wstrb,
    output logic      [1:0]            s_bvalid,
    input  wire logic [1:0]            s_bready,
    output logic      [1:0][1:0]       s_bresp,
    input  wire logic [1:0]            s_arvalid,
    output logic      [1:0]            s_arready,
    input  wire logic [1:0][7:0]       s_araddr,
    output logic      [1:0]            s_rvalid,
    input  wire logic [1:0]            s_rready,
    output logic      [1:0][31:0]      s_rdata,
    output logic      [1:0][1:0]       s_rresp,
    input  wire logic [31:0]           lock_state,
    output logic      [29:0]           pad_drive_enable,
    output logic      [5:0]            flash_pad_level,
    output logic      [5:0]            flash_pad_drive_enable,
    output logic      [1:0]            core_irq
);

    localparam int PTR_W = $clog2(MB_DEPTH);
    localparam int CNT_W = $clog2(MB_DEPTH + 1);
    localparam int DCW   = $clog2(DIV_CYCLES + 1);
    localparam logic [CNT_W-1:0] MB_FULL = CNT_W'(MB_DEPTH);
    localparam logic [DCW-1:0]   DIV_LOAD = DCW'(DIV_CYCLES);
    localparam logic [DCW-1:0]   DIV_LAST = DCW'(1);

    // ============================================================
    // Decode helpers
    function automatic logic is_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a >= scm_pkg::OFF_PAD_OE_CLR) &&
               (a <= scm_pkg::OFF_DIV_CSR);
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Byte-lane merge of a plain write
    function automatic logic [31:0] wmerge(input logic [31:0] v,
                                           input logic [31:0] d,
                                           input logic [31:0] m);
        return (v & ~m) | (d & m);
    endfunction

    // One core's effect on an aliased register group
    function automatic logic [31:0] alias_apply(input logic [31:0] v,
                                                input logic        en,
                                                input logic [7:0]  a,
                                                input logic [3:0]  grp,
                                                input logic [1:0]  min_op,
                                                input logic [31:0] d,
                                                input logic [31:0] m);
        logic [1:0] op;
        op = a[3:2];
        if (!en || a[7:4] != grp || a[1:0] != 2'h0 || op < min_op) begin
            return v;
        end
        case (op)
            scm_pkg::ALIAS_RW:  return wmerge(v, d, m);
            scm_pkg::ALIAS_SET: return v | (d & m);
            scm_pkg::ALIAS_CLR: return v & ~(d & m);
            default:            return v ^ (d & m);
        endcase
    endfunction

    // ============================================================
    // Shared per-core access signals
    logic [1:0]            we, re, push_req, pop_req, flag_clr;
    logic [1:0][31:0]      wm, mb_head;
    logic [1:0][3:0]       flags;
    logic [1:0][CNT_W-1:0] mb_cnt;
    logic [29:0]           pad_oe_q;
    logic [5:0]            flash_lvl_q, flash_oe_q;
    logic [1:0]            wof_q, roe_q;
    logic [31:0]           num_q, den_q, quot_q, rem_q, div_csr;
    logic [DCW-1:0]        dcnt_q;
    logic                  dirty_q;

    assign div_csr = {30'h0, dirty_q, dcnt_q == '0};

    // ============================================================
    // AXI4-Lite slave, one per core
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_core
            localparam int O = 1 - c;
            logic        bvalid_q, rvalid_q;
            logic [1:0]  bresp_q, rresp_q;
            logic [31:0] rdata_q, rmux;
            logic [7:0]  ra;

            // Write taken only with address and data both present
            assign we[c]        = s_awvalid[c] & s_wvalid[c] & ~bvalid_q;
            assign s_awready[c] = we[c];
            assign s_wready[c]  = we[c];
            assign re[c]        = s_arvalid[c] & ~rvalid_q;
            assign s_arready[c] = re[c];
            assign wm[c]        = strb_mask(s_wstrb[c]);
            assign ra           = s_araddr[c];
            assign s_bvalid[c]  = bvalid_q;
            assign s_bresp[c]   = bresp_q;
            assign s_rvalid[c]  = rvalid_q;
            assign s_rdata[c]   = rdata_q;
            assign s_rresp[c]   = rresp_q;

            // Mailbox requests and flag view of this core
            assign push_req[c] = we[c] &&
                                 s_awaddr[c] == scm_pkg::OFF_MB_PUSH;
            assign pop_req[c]  = re[c] &&
                                 ra == scm_pkg::OFF_MB_POP;
            assign flag_clr[c] = we[c] &&
                                 s_awaddr[c] == scm_pkg::OFF_MB_FLAGS;
            assign flags[c][scm_pkg::MB_VLD_BIT] = mb_cnt[O] != '0;
            assign flags[c][scm_pkg::MB_RDY_BIT] = mb_cnt[c] != MB_FULL;
            assign flags[c][scm_pkg::MB_WOF_BIT] = wof_q[c];
            assign flags[c][scm_pkg::MB_ROE_BIT] = roe_q[c];
            assign core_irq[c] = flags[c][scm_pkg::MB_VLD_BIT] |
                                 wof_q[c] | roe_q[c];

            // Read data selection; write-only aliases read zero
            assign rmux =
                (ra == scm_pkg::OFF_FLASH_LVL) ? {26'h0, flash_lvl_q} :
                (ra == scm_pkg::OFF_FLASH_OE)  ? {26'h0, flash_oe_q}  :
                (ra == scm_pkg::OFF_MB_FLAGS)  ? {28'h0, flags[c]}    :
                (ra == scm_pkg::OFF_MB_POP)    ?
                    ((mb_cnt[O] != '0) ? mb_head[O] : 32'h0)         :
                (ra == scm_pkg::OFF_LOCK_MAP)  ? lock_state           :
                (ra == scm_pkg::OFF_NUM_U ||
                 ra == scm_pkg::OFF_NUM_S)     ? num_q                :
                (ra == scm_pkg::OFF_DEN_U ||
                 ra == scm_pkg::OFF_DEN_S)     ? den_q                :
                (ra == scm_pkg::OFF_QUOT)      ? quot_q               :
                (ra == scm_pkg::OFF_REM)       ? rem_q                :
                (ra == scm_pkg::OFF_DIV_CSR)   ? div_csr              :
                32'h0;

            // Write response
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    bvalid_q <= 1'b0;
                    bresp_q  <= scm_pkg::RESP_OKAY;
                end else if (we[c]) begin
                    bvalid_q <= 1'b1;
                    bresp_q  <= is_mapped(s_awaddr[c]) ? scm_pkg::RESP_OKAY
                                                       : scm_pkg::RESP_SLVERR;
                end else if (s_bready[c]) begin
                    bvalid_q <= 1'b0;
                end
            end

            // Read response, data captured at the address handshake
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    rvalid_q <= 1'b0;
                    rdata_q  <= scm_pkg::RST_WORD;
                    rresp_q  <= scm_pkg::RESP_OKAY;
                end else if (re[c]) begin
                    rvalid_q <= 1'b1;
                    rdata_q  <= rmux;
                    rresp_q  <= is_mapped(ra) ? scm_pkg::RESP_OKAY
                                              : scm_pkg::RESP_SLVERR;
                end else if (s_rready[c]) begin
                    rvalid_q <= 1'b0;
                end
            end
        end
    endgenerate

    // ============================================================
    // Mailbox queues: queue f is filled by core f, drained by the other
    genvar f;
    generate
        for (f = 0; f < 2; f++) begin : g_mbox
            logic [31:0]      mem [MB_DEPTH];
            logic [PTR_W-1:0] wp_q, rp_q;
            logic [CNT_W-1:0] cnt_q;
            logic             do_push, do_pop;

            assign do_push    = push_req[f] && cnt_q != MB_FULL;
            assign do_pop     = pop_req[1-f] && cnt_q != '0;
            assign mb_cnt[f]  = cnt_q;
            assign mb_head[f] = mem[rp_q];

            // Storage, not reset
            always_ff @(posedge sys_clk) begin
                if (do_push) begin
                    mem[wp_q] <= s_wdata[f];
                end
            end

            // Pointers and fill level, emptied by reset
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    wp_q  <= '0;
                    rp_q  <= '0;
                    cnt_q <= '0;
                end else begin
                    wp_q  <= do_push ? wp_q + 1'b1 : wp_q;
                    rp_q  <= do_pop ? rp_q + 1'b1 : rp_q;
                    cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
                end
            end
        end
    endgenerate

    // Sticky error flags; a new error wins over the clearing write
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wof_q <= 2'h0;
            roe_q <= 2'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                wof_q[k] <= (push_req[k] && mb_cnt[k] == MB_FULL) ||
                            (wof_q[k] && !flag_clr[k]);
                roe_q[k] <= (pop_req[k] && mb_cnt[1-k] == '0) ||
                            (roe_q[k] && !flag_clr[k]);
            end
        end
    end

    // ============================================================
    // Pad registers: core zero's write, then core one's on top
    logic [31:0] pad_mid, pad_nx, lvl_mid, lvl_nx, foe_mid, foe_nx;

    assign pad_mid = alias_apply({2'h0, pad_oe_q}, we[0], s_awaddr[0],
                                 scm_pkg::GRP_PAD_OE, scm_pkg::ALIAS_CLR,
                                 s_wdata[0], wm[0]);
    assign pad_nx  = alias_apply(pad_mid, we[1], s_awaddr[1],
                                 scm_pkg::GRP_PAD_OE, scm_pkg::ALIAS_CLR,
                                 s_wdata[1], wm[1]);
    assign lvl_mid = alias_apply({26'h0, flash_lvl_q}, we[0], s_awaddr[0],
                                 scm_pkg::GRP_FLASH_LVL, scm_pkg::ALIAS_RW,
                                 s_wdata[0], wm[0]);
    assign lvl_nx  = alias_apply(lvl_mid, we[1], s_awaddr[1],
                                 scm_pkg::GRP_FLASH_LVL, scm_pkg::ALIAS_RW,
                                 s_wdata[1], wm[1]);
    assign foe_mid = alias_apply({26'h0, flash_oe_q}, we[0], s_awaddr[0],
                                 scm_pkg::GRP_FLASH_OE, scm_pkg::ALIAS_RW,
                                 s_wdata[0], wm[0]);
    assign foe_nx  = alias_apply(foe_mid, we[1], s_awaddr[1],
                                 scm_pkg::GRP_FLASH_OE, scm_pkg::ALIAS_RW,
                                 s_wdata[1], wm[1]);

    // Pad state, reserved bits dropped
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pad_oe_q    <= scm_pkg::RST_PAD_OE;
            flash_lvl_q <= scm_pkg::RST_FLASH;
            flash_oe_q  <= scm_pkg::RST_FLASH;
        end else begin
            pad_oe_q    <= pad_nx[29:0];
            flash_lvl_q <= lvl_nx[5:0];
            flash_oe_q  <= foe_nx[5:0];
        end
    end

    assign pad_drive_enable       = pad_oe_q;
    assign flash_pad_level        = flash_lvl_q;
    assign flash_pad_drive_enable = flash_oe_q;

    // ============================================================
    // Divider: operand and result writes, same core ordering
    logic [1:0]  num_hit, den_hit, quo_hit, rem_hit, div_wr;
    logic [31:0] num_mid, num_nx, den_mid, den_nx;
    logic [31:0] quo_mid, quo_nx, rem_mid, rem_nx;
    logic        start, halt, sgn_nx, done, quot_rd;

    generate
        for (c = 0; c < 2; c++) begin : g_div_dec
            logic [7:0] a;
            assign a = s_awaddr[c];
            assign num_hit[c] = we[c] && (a == scm_pkg::OFF_NUM_U ||
                                          a == scm_pkg::OFF_NUM_S);
            assign den_hit[c] = we[c] && (a == scm_pkg::OFF_DEN_U ||
                                          a == scm_pkg::OFF_DEN_S);
            assign quo_hit[c] = we[c] && a == scm_pkg::OFF_QUOT;
            assign rem_hit[c] = we[c] && a == scm_pkg::OFF_REM;
            assign div_wr[c]  = num_hit[c] | den_hit[c] |
                                quo_hit[c] | rem_hit[c];
        end
    endgenerate

    assign num_mid = num_hit[0] ? wmerge(num_q, s_wdata[0], wm[0]) : num_q;
    assign num_nx  = num_hit[1] ? wmerge(num_mid, s_wdata[1], wm[1])
                                : num_mid;
    assign den_mid = den_hit[0] ? wmerge(den_q, s_wdata[0], wm[0]) : den_q;
    assign den_nx  = den_hit[1] ? wmerge(den_mid, s_wdata[1], wm[1])
                                : den_mid;
    assign quo_mid = quo_hit[0] ? wmerge(quot_q, s_wdata[0], wm[0]) : quot_q;
    assign quo_nx  = quo_hit[1] ? wmerge(quo_mid, s_wdata[1], wm[1])
                                : quo_mid;
    assign rem_mid = rem_hit[0] ? wmerge(rem_q, s_wdata[0], wm[0]) : rem_q;
    assign rem_nx  = rem_hit[1] ? wmerge(rem_mid, s_wdata[1], wm[1])
                                : rem_mid;

    // Start, halt and mode; the later core picks the mode
    assign start   = |(num_hit | den_hit);
    assign halt    = |(quo_hit | rem_hit);
    assign sgn_nx  = (num_hit[1] | den_hit[1]) ? s_awaddr[1][3]
                                               : s_awaddr[0][3];
    assign done    = dcnt_q == DIV_LAST && !start && !halt;
    assign quot_rd = |(re & {s_araddr[1] == scm_pkg::OFF_QUOT,
                             s_araddr[0] == scm_pkg::OFF_QUOT});

    // Latched operands and the signed result fix-up
    logic [31:0] cn_q, cd_q, an, ad, uq, ur, q_res, r_res;
    logic        cs_q, neg_n, neg_d;

    assign neg_n = cs_q & cn_q[31];
    assign neg_d = cs_q & cd_q[31];
    assign an    = neg_n ? -cn_q : cn_q;
    assign ad    = neg_d ? -cd_q : cd_q;
    assign uq    = (ad == 32'h0) ? 32'hffffffff : an / ad;
    assign ur    = (ad == 32'h0) ? an : an % ad;
    assign q_res = (neg_n ^ neg_d) ? -uq : uq;
    assign r_res = neg_n ? -ur : ur;

    // Divider state
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            num_q   <= scm_pkg::RST_WORD;
            den_q   <= scm_pkg::RST_WORD;
            quot_q  <= scm_pkg::RST_WORD;
            rem_q   <= scm_pkg::RST_WORD;
            cn_q    <= scm_pkg::RST_WORD;
            cd_q    <= scm_pkg::RST_WORD;
            cs_q    <= 1'b0;
            dcnt_q  <= '0;
            dirty_q <= 1'b0;
        end else begin
            num_q  <= num_nx;
            den_q  <= den_nx;
            quot_q <= done ? q_res : quo_nx;
            rem_q  <= done ? r_res : rem_nx;
            if (start) begin
                cn_q   <= num_nx;
                cd_q   <= den_nx;
                cs_q   <= sgn_nx;
                dcnt_q <= DIV_LOAD;
            end else if (halt) begin
                dcnt_q <= '0;
            end else if (dcnt_q != '0) begin
                dcnt_q <= dcnt_q - 1'b1;
            end
            dirty_q <= (|div_wr) || (dirty_q && !quot_rd);
        end
    end

endmodule

`default_nettype wire

// >>> hw/scm_pkg.sv
// Constants for the single-cycle IO register slice.
// Assumes byte addresses on an 8-bit AXI4-Lite address bus.
// ============================================================
// Package
package scm_pkg;
    // Bus geometry and answers
    localparam int          ADDR_W      = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Register byte offsets
    localparam logic [7:0]  OFF_PAD_OE_CLR   = 8'h28;
    localparam logic [7:0]  OFF_PAD_OE_XOR   = 8'h2c;
    localparam logic [7:0]  OFF_FLASH_LVL    = 8'h30;
    localparam logic [7:0]  OFF_FLASH_LVL_S  = 8'h34;
    localparam logic [7:0]  OFF_FLASH_LVL_C  = 8'h38;
    localparam logic [7:0]  OFF_FLASH_LVL_X  = 8'h3c;
    localparam logic [7:0]  OFF_FLASH_OE     = 8'h40;
    localparam logic [7:0]  OFF_FLASH_OE_S   = 8'h44;
    localparam logic [7:0]  OFF_FLASH_OE_C   = 8'h48;
    localparam logic [7:0]  OFF_FLASH_OE_X   = 8'h4c;
    localparam logic [7:0]  OFF_MB_FLAGS     = 8'h50;
    localparam logic [7:0]  OFF_MB_PUSH      = 8'h54;
    localparam logic [7:0]  OFF_MB_POP       = 8'h58;
    localparam logic [7:0]  OFF_LOCK_MAP     = 8'h5c;
    localparam logic [7:0]  OFF_NUM_U        = 8'h60;
    localparam logic [7:0]  OFF_DEN_U        = 8'h64;
    localparam logic [7:0]  OFF_NUM_S        = 8'h68;
    localparam logic [7:0]  OFF_DEN_S        = 8'h6c;
    localparam logic [7:0]  OFF_QUOT         = 8'h70;
    localparam logic [7:0]  OFF_REM          = 8'h74;
    localparam logic [7:0]  OFF_DIV_CSR      = 8'h78;
    // Alias groups: upper address nibble, op in bits 3:2
    localparam logic [3:0]  GRP_PAD_OE    = 4'h2;
    localparam logic [3:0]  GRP_FLASH_LVL = 4'h3;
    localparam logic [3:0]  GRP_FLASH_OE  = 4'h4;
    localparam logic [1:0]  ALIAS_RW      = 2'h0;
    localparam logic [1:0]  ALIAS_SET     = 2'h1;
    localparam logic [1:0]  ALIAS_CLR     = 2'h2;
    // Widths
    localparam int          PAD_W   = 30;
    localparam int          FLASH_W = 6;
    localparam int          LOCK_N  = 32;
    localparam int          MB_DEPTH = 8;
    // Mailbox flag bit positions
    localparam int          MB_VLD_BIT = 0;
    localparam int          MB_RDY_BIT = 1;
    localparam int          MB_WOF_BIT = 2;
    localparam int          MB_ROE_BIT = 3;
    // Divider status bit positions and latency
    localparam int          DIVISION_DONE_FLAG_BIT = 0;
    localparam int          RESULT_UNSAVED_FLAG_BIT = 1;
    localparam int          DIV_CYCLES    = 8;
    // Values after reset
    localparam logic [29:0] RST_PAD_OE = 30'h0;
    localparam logic [5:0]  RST_FLASH  = 6'h0;
    localparam logic [31:0] RST_WORD   = 32'h0;
endpackage

// >>> test/scm_sio_checker.sv
// Port checks on the register slice: bus answers and register effects.
// Assumes full byte strobes on every write from the bench.
`timescale 1ns/10ps
`default_nettype none
// ============================================
// Checker
module scm_sio_checker (
    input wire logic                  sys_clk, rstn,
    input wire logic [1:0]            s_awvalid, s_awready, s_rvalid,
    input wire logic [1:0]            s_arvalid, s_arready, s_bvalid, core_irq,
    input wire logic [1:0][7:0]       s_awaddr,
    input wire logic [1:0][31:0]      s_wdata,
    input wire logic [29:0]           pad_drive_enable,
    input wire logic [5:0]            flash_pad_level
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Writes taken, alone or from both cores at once
    wire logic [1:0] tk = s_awvalid & s_awready;
    wire logic solo = tk == 2'h1;
    wire logic dual = tk == 2'h3 && s_awaddr == {8'h38, 8'h34};
    chk_write_answer: assert property (tk[0] |=> s_bvalid[0])
        else $error("write not answered");
    chk_read_answer: assert property (s_arvalid[1] & s_arready[1] |=> s_rvalid[1])
        else $error("read not answered");
    chk_read_refused: assert property (s_rvalid[0] |-> !s_arready[0])
        else $error("read taken while busy");
    chk_reset_quiet: assert property ($rose(rstn) |->
        !core_irq && !pad_drive_enable)
        else $error("outputs not clear after reset");
    chk_pad_clear: assert property (solo && s_awaddr[0] == 8'h28 |=>
        pad_drive_enable == ($past(pad_drive_enable) & ~$past(s_wdata[0][29:0])))
        else $error("pad enable clear wrong");
    chk_pad_toggle: assert property (solo && s_awaddr[0] == 8'h2c |=>
        pad_drive_enable == ($past(pad_drive_enable) ^ $past(s_wdata[0][29:0])))
        else $error("pad enable toggle wrong");
    chk_level_order: assert property (dual |=> flash_pad_level ==
        (($past(flash_pad_level) | $past(s_wdata[0][5:0])) & ~$past(s_wdata[1][5:0])))
        else $error("dual write order wrong");
    chk_push_wakes: assert property (solo && s_awaddr[0] == 8'h54
        |=> core_irq[1]) else $error("push raised no interrupt");
    cover property (dual);
    cover property (solo && s_awaddr[0] == 8'h54);
    cover property (s_rvalid == 2'h2);
endmodule
bind scm_sio_regs scm_sio_checker chk (.*);
`default_nettype wire

// >>> test/scm_core_bfm.sv
// Bus master model of both cores issuing register accesses.
// Assumes one AXI4-Lite slave port per core on a rising-edge clock.
`timescale 1ns/10ps
`default_nettype none
// ============================================
// Master model
module scm_core_bfm (
    input  wire logic             clk,
    output var  logic [1:0]       awv, wv, arv,
    output var  logic [1:0][7:0]  aa, ra,
    output var  logic [1:0][31:0] wd,
    output wire logic [1:0]       br, rr,
    input  wire logic [1:0]       awr, bv, arr, rv,
    input  wire logic [1:0][31:0] rd_q
);
    assign br = 2'h3; // Always accepting answers
    assign rr = 2'h3;
    initial {awv, wv, arv, aa, ra, wd} = '0;
    // Write: both channels held until taken, then wait for response
    task automatic wr(input int c, input logic [7:0] a, input logic [31:0] d);
        awv[c] <= 1'b1; wv[c] <= 1'b1; aa[c] <= a; wd[c] <= d;
        do @(posedge clk); while (awr[c] !== 1'b1);
        awv[c] <= 1'b0; wv[c] <= 1'b0; aa[c] <= ~a; wd[c] <= ~d;
        do @(posedge clk); while (bv[c] !== 1'b1);
    endtask
    // Read: address held until taken, data taken with rvalid
    task automatic rd(input int c, input logic [7:0] a, output logic [31:0] d);
        arv[c] <= 1'b1; ra[c] <= a;
        do @(posedge clk); while (arr[c] !== 1'b1);
        arv[c] <= 1'b0; ra[c] <= ~a;
        do @(posedge clk); while (rv[c] !== 1'b1);
        d = rd_q[c];
    endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench: two cores reach the register slice.
// Assumes the master model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed {logic c; logic [7:0] wa; logic [31:0] wd;
                           logic [7:0] ra; logic [31:0] ex;} scm_row_s;
    logic sys_clk = 1'b0, rstn = 1'b0;
    logic [31:0] lock_state = 32'h5a0fc3e1, d;
    int num_errors = 0, checks_done = 0;
    wire logic [1:0] s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    wire logic [1:0] s_arvalid, s_arready, s_rvalid, s_rready, core_irq;
    wire logic [1:0][7:0] s_awaddr, s_araddr;
    wire logic [1:0][31:0] s_wdata, s_rdata;
    wire logic [1:0][1:0] s_bresp, s_rresp;
    wire logic [1:0][3:0] s_wstrb = '1;
    wire logic [29:0] pad_drive_enable;
    wire logic [5:0] flash_pad_level, flash_pad_drive_enable;
    // Rows: core, write addr (0 none), data, read addr (0 pads), expected
    scm_row_s rows [12] = '{'{0,0,0,8'h50,2}, '{1,0,0,8'h78,1},
        '{1,0,0,8'h5c,32'h5a0fc3e1}, '{0,8'h2c,32'h3fffffff,0,32'h3fffffff},
        '{0,8'h28,32'hffff,0,32'h3fff0000}, '{0,8'h30,32'hffffffff,8'h30,32'h3f},
        '{1,8'h3c,5,8'h30,32'h3a}, '{0,8'h44,32'hf,8'h40,32'hf},
        '{1,8'h48,3,8'h40,32'hc}, '{0,8'h4c,32'h21,8'h40,32'h2d},
        '{0,8'h6c,32'h2,8'h64,32'h2}, '{1,0,0,8'h7c,0}};
    always #10 sys_clk = ~sys_clk;
    scm_sio_regs uut (.*);
    scm_core_bfm m (.clk(sys_clk), .awv(s_awvalid), .wv(s_wvalid), .aa(s_awaddr),
        .wd(s_wdata), .br(s_bready), .arv(s_arvalid), .ra(s_araddr), .rr(s_rready),
        .awr(s_awready), .bv(s_bvalid), .arr(s_arready), .rv(s_rvalid), .rd_q(s_rdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog well beyond the hundred-odd cycles the tests need
    initial begin
        #100000;
        num_errors++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wa != 0) m.wr(rows[i].c, rows[i].wa, rows[i].wd);
            if (rows[i].ra != 0) m.rd(rows[i].c, rows[i].ra, d);
            else d = {2'h0, pad_drive_enable};
            check(d, rows[i].ex);
        end
        check({s_rresp[1], flash_pad_drive_enable}, 32'had);
        fork
            m.wr(0, 8'h34, 32'h05);
            m.wr(1, 8'h38, 32'h03);
        join
        check({26'h0, flash_pad_level}, 32'h3c);
        for (int i = 1; i <= 9; i++) m.wr(0, 8'h54, i);
        m.rd(0, 8'h50, d);
        check(d, 32'h4);
        for (int i = 1; i <= 9; i++) begin
            m.rd(1, 8'h58, d);
            check(d, i <= 8 ? i : 0);
        end
        m.rd(1, 8'h50, d);
        check(d, 32'ha);
        check({30'h0, core_irq}, 32'h3);
        m.wr(1, 8'h50, 0);
        check({30'h0, core_irq}, 32'h1);
        m.wr(0, 8'h68, 32'hfffffff9);
        m.rd(0, 8'h78, d);
        check(d, 32'h2);
        do m.rd(0, 8'h78, d); while (d[0] !== 1'b1);
        m.rd(0, 8'h74, d);
        check(d, 32'hffffffff);
        m.rd(0, 8'h70, d);
        check(d, 32'hfffffffd);
        m.rd(0, 8'h78, d);
        check(d, 32'h1);
        m.wr(1, 8'h60, 32'hfffffff9);
        do m.rd(1, 8'h78, d); while (d[0] !== 1'b1);
        m.rd(1, 8'h70, d);
        check(d, 32'h7ffffffc);
        m.wr(0, 8'h64, 32'h3);
        m.wr(0, 8'h74, 32'h9);
        m.rd(0, 8'h78, d);
        check(d, 32'h3);
        summarize;
    end
endmodule
`default_nettype wire
